// [iee_engine.sv]
// Two-wire EEPROM slave engine: select, write, page buffer, program cycle, reads
`timescale 1ns/10ps
`default_nettype none
module iee_engine #(
  parameter int unsigned PROG_CYCLES = iee_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH = iee_pkg::PAGE_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic upper_half_write_protect,
  input wire logic [1:0] chip_enable,
  output logic write_busy
);
  localparam int ENTRY_W = $bits(iee_pkg::iee_wr_entry_t);

  iee_pkg::iee_eng_st_t st_r;
  iee_pkg::iee_eng_st_t st_nxt;
  logic [7:0] mem [0:iee_pkg::MEM_BYTES-1];

  iee_pkg::iee_pins_t pins_raw;
  iee_pkg::iee_pins_t pins;
  logic [4:0] pins_q;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sel_match;
  logic protect_hit;
  logic [7:0] rd_byte;

  logic mem_we;
  logic [iee_pkg::ADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;

  logic fifo_flush;
  logic fifo_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  iee_pkg::iee_wr_entry_t fifo_in;
  iee_pkg::iee_wr_entry_t fifo_out;
  logic [ENTRY_W-1:0] fifo_out_bits;

  // Every pin input crosses two flops before use
  assign pins_raw.ce = chip_enable;
  assign pins_raw.wp = upper_half_write_protect;
  assign pins_raw.sda = sda_in;
  assign pins_raw.scl = scl_in;

  iee_sync #(
    .W(5),
    .RST_VAL(iee_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_q)
  );

  assign pins = pins_q;

  // Bus events from the synchronised levels and their last samples
  assign scl_rise = pins.scl & ~st_r.scl_d;
  assign scl_fall = ~pins.scl & st_r.scl_d;
  assign start_seen = st_r.scl_d & pins.scl & st_r.sda_d & ~pins.sda;
  assign stop_seen = st_r.scl_d & pins.scl & ~st_r.sda_d & pins.sda;

  // Type identifier and chip enable must both match
  assign sel_match = (st_r.sh[7:4] == iee_pkg::DEV_TYPE_ID) // RQ23
                   & (st_r.sh[3:2] == pins.ce);

  // Protection covers only the upper half of the array
  assign protect_hit = st_r.wp_seen & st_r.addr[iee_pkg::PROT_BIT]; // RQ21

  assign rd_byte = mem[st_r.addr];

  // Page bytes wait here until the Stop commits them
  assign fifo_in.low = st_r.addr[iee_pkg::PAGE_LOW_W-1:0];
  assign fifo_in.data = st_r.sh;
  assign fifo_out = fifo_out_bits;

  iee_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_page_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_bits)
  );

  // Main sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_d = pins.scl;
    st_nxt.sda_d = pins.sda;
    fifo_flush = 1'b0;
    fifo_push = 1'b0;
    fifo_out_ready = 1'b0;
    mem_we = 1'b0;
    mem_wa = st_r.addr;
    mem_wd = iee_pkg::ERASED_BYTE;
    case (st_r.st)
      // Sweep the array to all ones before the bus is served
      iee_pkg::ST_INIT: begin
        mem_we = 1'b1; // RQ20
        st_nxt.addr = st_r.addr + 1'b1;
        if (st_r.addr == iee_pkg::ADDR_LAST) begin
          st_nxt.st = iee_pkg::ST_IDLE;
          st_nxt.busy = 1'b0;
        end
      end
      // Detached from the bus: drain the page, then wait out the timer
      iee_pkg::ST_PROG: begin
        fifo_out_ready = 1'b1; // RQ8
        if (fifo_out_valid) begin
          mem_we = 1'b1; // RQ4
          mem_wa = {st_r.addr[iee_pkg::ADDR_W-1:iee_pkg::PAGE_LOW_W], fifo_out.low};
          mem_wd = fifo_out.data;
        end
        st_nxt.tmr = st_r.tmr + 1'b1;
        // Polls are ignored until this point, then answered again
        if (st_r.tmr >= PROG_CYCLES - 1 && !fifo_out_valid) begin // RQ25 RQ9 RQ10
          st_nxt.st = iee_pkg::ST_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.tmr = '0;
        end
      end
      default: begin
        if (start_seen) begin
          // Start or restart; stray page bytes are dropped
          st_nxt.st = iee_pkg::ST_SEL;
          st_nxt.cnt = '0;
          st_nxt.drive = 1'b0;
          st_nxt.last_ack = 1'b0;
          st_nxt.wp_seen = pins.wp; // RQ2
          fifo_flush = 1'b1;
        end else if (stop_seen) begin
          st_nxt.drive = 1'b0;
          st_nxt.cnt = '0;
          st_nxt.last_ack = 1'b0;
          // Only a Stop straight after an ack slot commits
          if (st_r.st == iee_pkg::ST_WDATA && st_r.last_ack && fifo_out_valid) begin // RQ22
            st_nxt.st = iee_pkg::ST_PROG;
            st_nxt.busy = 1'b1;
            st_nxt.tmr = '0;
          end else begin
            st_nxt.st = iee_pkg::ST_IDLE;
            fifo_flush = 1'b1;
          end
        end else if (st_r.st != iee_pkg::ST_IDLE) begin
          if (st_r.st == iee_pkg::ST_SEL || st_r.st == iee_pkg::ST_ADDR) begin
            st_nxt.wp_seen = st_r.wp_seen | pins.wp; // RQ2
          end
          if (scl_rise) begin
            if (st_r.cnt != iee_pkg::BIT_ACK_END) begin
              st_nxt.cnt = st_r.cnt + 1'b1;
            end
            if (st_r.cnt <= iee_pkg::BIT_LAST) begin
              st_nxt.sh = {st_r.sh[6:0], pins.sda};
            end
            // Master left the ninth slot high: end and go to standby
            if (st_r.st == iee_pkg::ST_RDATA && st_r.cnt == iee_pkg::BIT_ACK
                && pins.sda) begin // RQ19
              st_nxt.st = iee_pkg::ST_IDLE;
              st_nxt.drive = 1'b0;
              st_nxt.cnt = '0;
            end
          end else if (scl_fall) begin
            // Stop window stays open through the high phase after an ack slot
            st_nxt.last_ack = 1'b0; // RQ22
            if (st_r.cnt == iee_pkg::BIT_ACK) begin
              case (st_r.st)
                iee_pkg::ST_SEL: begin
                  if (sel_match) begin // RQ23
                    st_nxt.drive = 1'b1;
                    st_nxt.addr[iee_pkg::ADDR_W-1] = st_r.sh[1]; // RQ24
                    // Read select goes to output; protect level not consulted
                    st_nxt.st = st_r.sh[0] ? iee_pkg::ST_RDATA : iee_pkg::ST_ADDR; // RQ12 RQ13
                  end else begin
                    st_nxt.st = iee_pkg::ST_IDLE;
                  end
                end
                iee_pkg::ST_ADDR: begin
                  st_nxt.drive = 1'b1;
                  st_nxt.addr[7:0] = st_r.sh;
                  st_nxt.st = iee_pkg::ST_WDATA;
                end
                iee_pkg::ST_WDATA: begin
                  // Protected or page buffer full: NoAck, byte dropped
                  if (!protect_hit && fifo_in_ready) begin // RQ2 RQ6 RQ3
                    st_nxt.drive = 1'b1;
                    fifo_push = 1'b1; // RQ4
                    st_nxt.addr[iee_pkg::PAGE_LOW_W-1:0] =
                      st_r.addr[iee_pkg::PAGE_LOW_W-1:0] + 1'b1; // RQ7
                  end
                end
                iee_pkg::ST_RDATA: begin
                  st_nxt.drive = 1'b0;
                end
                default: begin
                  st_nxt.drive = 1'b0;
                end
              endcase
            end else if (st_r.cnt == iee_pkg::BIT_ACK_END) begin
              st_nxt.cnt = '0;
              if (st_r.st == iee_pkg::ST_RDATA) begin
                // Next byte out, counter steps after the fetch, wraps at the top
                st_nxt.tx = rd_byte; // RQ15 RQ16
                st_nxt.addr = st_r.addr + 1'b1; // RQ18
                st_nxt.drive = ~rd_byte[7];
              end else begin
                st_nxt.drive = 1'b0;
                st_nxt.last_ack = 1'b1; // RQ22
              end
            end else if (st_r.st == iee_pkg::ST_RDATA && st_r.cnt != '0) begin
              // Shift out while the clock is low
              st_nxt.tx = {st_r.tx[6:0], 1'b0};
              st_nxt.drive = ~st_r.tx[6];
            end
          end
        end
      end
    endcase
    st_nxt.sda_o = ~st_nxt.drive;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= iee_pkg::ENG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Array write port; no reset, the init sweep fills it
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open-drain data: enable high pulls low
  assign sda_oe = st_r.drive;
  assign sda_out = st_r.sda_o;
  assign write_busy = st_r.busy;
endmodule : iee_engine
`default_nettype wire

// [iee_pkg.sv]
// Constants, states and carriers for the two-wire EEPROM engine
//
// Behaviour
// RQ1: Byte write is select, address, one data byte, then Stop from the master.
// RQ2: Protect input high from Start to address end on upper half: NoAck data, no change.
// RQ3: Unprotected write data bytes are all acknowledged; the code gives NoAck to any byte past the sixteenth of a page write.
// RQ4: Page write takes one to sixteen bytes of one page, committed in one cycle.
// RQ5: Master avoids sending past the page end since wrapping overwrites data.
// RQ6: Protected page write answers every data byte with NoAck, nothing modified.
// RQ7: After each written byte only the low four address bits increment.
// RQ8: During the internal write cycle the bus is ignored while data is committed.
// RQ9: Master polls with Start plus select; busy device gives no acknowledge.
// RQ10: After the write cycle a select byte is acknowledged as a new command.
// RQ11: Random read repeats the same upper seven select bits after restart.
// RQ12: Reads behave the same whatever the protect input level.
// RQ13: Random read: address by write preamble, restart with read bit, byte returned.
// RQ14: Master does not acknowledge the random read byte and sends Stop.
// RQ15: Current-address read returns byte at the counter, then increments it.
// RQ16: Acknowledged output byte is followed by the next address, counter increments.
// RQ17: Master ends a sequential read with NoAck then Stop.
// RQ18: Read counter wraps from the last address to zero.
// RQ19: Ninth slot of each read byte sampled; high ends transfer into standby.
// RQ20: Array holds all ones initially, every byte reads ff.
// RQ21: Protect input blocks writes only to addresses 100h to 1ffh.
// RQ22: Write cycle starts only on Stop right after an acknowledge slot.
// RQ23: Respond only when select upper four bits match the type identifier.
// RQ24: Address counter is nine bits, top bit from the select byte.
// RQ25: Write cycle ends after a parameter-set time, then select bytes answered.
`default_nettype none
package iee_pkg;
  localparam int ADDR_W = 9;
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_LOW_W = 4;
  localparam int PROT_BIT = 8;
  localparam int CLK_HZ = 40_000_000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  // Arbitrary value, stands in for the memory type identifier
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [8:0] ADDR_LAST = 9'h1ff;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;
  localparam logic [4:0] SYNC_RST = 5'h03;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SEL = 3'b010,
    ST_ADDR = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101,
    ST_PROG = 3'b110
  } iee_state_t;

  typedef struct packed {
    logic [PAGE_LOW_W-1:0] low;
    logic [7:0] data;
  } iee_wr_entry_t;

  typedef struct packed {
    logic [1:0] ce;
    logic wp;
    logic sda;
    logic scl;
  } iee_pins_t;

  typedef struct packed {
    iee_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [ADDR_W-1:0] addr;
    logic wp_seen;
    logic last_ack;
    logic drive;
    logic sda_o;
    logic busy;
    logic scl_d;
    logic sda_d;
    logic [31:0] tmr;
  } iee_eng_st_t;

  localparam iee_eng_st_t ENG_RST = '{
    st: ST_INIT, cnt: 4'h0, sh: 8'h00, tx: 8'h00, addr: 9'h000,
    wp_seen: 1'b0, last_ack: 1'b0, drive: 1'b0, sda_o: 1'b1, busy: 1'b1,
    scl_d: 1'b1, sda_d: 1'b1, tmr: 32'h0000_0000};
endpackage : iee_pkg
`default_nettype wire

// [iee_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module iee_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } iee_sync_st_t;

  iee_sync_st_t st_r;
  iee_sync_st_t st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : iee_sync
`default_nettype wire

// [iee_fifo.sv]
// Page buffer FIFO with valid/ready on both sides and flush
`timescale 1ns/10ps
`default_nettype none
module iee_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0] cnt;
  } iee_fifo_st_t;

  iee_fifo_st_t st_r;
  iee_fifo_st_t st_nxt;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (st_r.cnt != CNT_FULL);
  assign out_valid = (st_r.cnt != '0);
  assign out_data = store[st_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update; flush drops everything held
  always_comb begin
    st_nxt = st_r;
    if (flush) begin
      st_nxt = '0;
    end else begin
      if (push) begin
        st_nxt.wp = (st_r.wp == PTR_LAST) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
        st_nxt.rp = (st_r.rp == PTR_LAST) ? '0 : st_r.rp + 1'b1;
      end
      if (push && !pop) begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage needs no reset; only counted entries are read
  always_ff @(posedge sys_clk) begin
    if (push && !flush) begin
      store[st_r.wp] <= in_data;
    end
  end
endmodule : iee_fifo
`default_nettype wire

// [iee_engine_asserts.sv]
// Port-level assertions for the two-wire EEPROM engine
`timescale 1ns/10ps
`default_nettype none
module iee_engine_asserts #(
  parameter int unsigned PROG_CYCLES = iee_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH = iee_pkg::PAGE_BYTES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic upper_half_write_protect,
  input wire logic [1:0] chip_enable,
  input wire logic write_busy
);
  localparam int CEIL = PROG_CYCLES + 600;
  // Init sweep is 512 cycles, so the floor never exceeds it
  localparam int FLOOR = PROG_CYCLES < 512 ? PROG_CYCLES - 1 : 511;
  logic [31:0] busy_cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Length of the current busy stretch
  always_ff @(posedge sys_clk)
    busy_cnt_r <= (write_busy && !rst) ? busy_cnt_r + 32'h1 : 32'h0;
  sequence s_stop;
    $rose(sda_in) && scl_in && $past(scl_in);
  endsequence
  sequence s_slot_end;
    ##[1:40] $rose(scl_in) ##[1:40] $fell(scl_in);
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> write_busy && !sda_oe)
    else $error("bus driven or idle right after reset");
  a_busy_silent: assert property (write_busy |-> !sda_oe)
    else $error("data driven during busy");
  a_oe_lag: assert property ($fell(scl_in) |=> $stable(sda_oe)[*2])
    else $error("data moved too soon after clock fall");
  a_high_hold: assert property ($rose(scl_in) |=> $stable(sda_oe)[*5])
    else $error("data moved while clock high");
  a_stop_release: assert property (s_stop |-> (!sda_oe)[*6])
    else $error("data driven after stop");
  a_slot_hold: assert property ($rose(sda_oe) |-> sda_oe throughout s_slot_end)
    else $error("low level dropped inside its slot");
  a_cycle_ceiling: assert property (write_busy |-> busy_cnt_r < CEIL)
    else $error("write cycle overran");
  a_cycle_floor: assert property ($fell(write_busy) |-> busy_cnt_r >= FLOOR)
    else $error("write cycle too short");
endmodule : iee_engine_asserts
bind iee_engine iee_engine_asserts #(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .upper_half_write_protect(upper_half_write_protect),
  .chip_enable(chip_enable), .write_busy(write_busy));
`default_nettype wire

// [iee_bus_master.sv]
// Two-wire bus master model: clock owner, open-drain data
`timescale 1ns/10ps
`default_nettype none
module iee_bus_master (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hc
  // Start or restart; clock left low for the first bit
  task automatic start_c();
    sda_drv = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b0;
    hc(8);
    scl = 1'b0;
    hc(4);
  endtask : start_c
  task automatic stop_c();
    sda_drv = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b1;
    hc(8);
  endtask : stop_c
  // Data moves mid-low only, so no false start or stop
  task automatic bit_c(input logic b, output logic s);
    sda_drv = b;
    hc(4);
    scl = 1'b1;
    hc(4);
    s = sda_line;
    hc(4);
    scl = 1'b0;
    hc(4);
  endtask : bit_c
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(d[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      d[i] = s;
    end
    bit_c(~give_ack, s);
  endtask : get_byte
endmodule : iee_bus_master
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the two-wire EEPROM engine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [1:0] ce = 2'h2;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  logic write_busy;
  wire logic sda_line;
  logic [7:0] img [512];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  // Pull-up wire: low when either party pulls
  assign sda_line = sda_drv & (~sda_oe | sda_out);
  always #12.5 sys_clk = ~sys_clk;
  iee_engine #(.PROG_CYCLES(400)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .upper_half_write_protect(wp), .chip_enable(ce),
    .write_busy(write_busy));
  iee_bus_master mst_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] sel(input logic a8, input logic rd);
    return {iee_pkg::DEV_TYPE_ID, ce, a8, rd};
  endfunction : sel
  task automatic head(input logic [8:0] a, output logic ak);
    logic k;
    mst_u.start_c();
    mst_u.put_byte(sel(a[8], 1'b0), k);
    mst_u.put_byte(a[7:0], ak);
    ak = ak & k;
  endtask : head
  // Bytes d0, d0+1...; image follows only where the write should land
  task automatic wr(input logic [8:0] a, input logic [7:0] d0, input int n, input logic ok,
                    output int acks);
    logic k;
    head(a, k);
    chk(9'(k), 9'h001);
    acks = 0;
    for (int i = 0; i < n; i++) begin
      mst_u.put_byte(d0 + 8'(i), k);
      if (k === 1'b1) acks++;
      if (ok && i < 16) img[{a[8:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
    end
    mst_u.stop_c();
  endtask : wr
  task automatic poll(output int tries);
    logic k;
    tries = 0;
    k = 1'b0;
    while (k !== 1'b1 && tries < 40) begin
      mst_u.start_c();
      mst_u.put_byte(sel(1'b0, 1'b0), k);
      tries++;
    end
    mst_u.stop_c();
  endtask : poll
  task automatic rd_tail(input logic [8:0] a, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      mst_u.get_byte(i < n - 1, d);
      chk(9'(d), 9'(img[a + 9'(i)]));
    end
    mst_u.stop_c();
  endtask : rd_tail
  task automatic rd(input logic [8:0] a, input int n);
    logic k;
    head(a, k);
    mst_u.start_c();
    mst_u.put_byte(sel(a[8], 1'b1), k);
    chk(9'(k), 9'h001);
    rd_tail(a, n);
  endtask : rd
  task automatic t_page();
    int n;
    int tries;
    logic k;
    rd(9'h005, 2);
    wr(9'h1f8, 8'h40, 17, 1'b1, n);
    chk(9'(n), 9'h010);
    poll(tries);
    chk(9'(tries > 1), 9'h001);
    chk(9'(tries < 40), 9'h001);
    rd(9'h1fe, 4);
    rd(9'h1f0, 1);
    mst_u.start_c();
    mst_u.put_byte(sel(1'b1, 1'b1), k);
    chk(9'(k), 9'h001);
    rd_tail(9'h1f1, 1);
    $display("t_page done");
  endtask : t_page
  task automatic t_protect();
    int n;
    int tries;
    wp = 1'b1;
    wr(9'h1a0, 8'h77, 2, 1'b0, n);
    chk(9'(n), 9'h000);
    rd(9'h1a0, 2);
    wr(9'h0a0, 8'h55, 1, 1'b1, n);
    chk(9'(n), 9'h001);
    poll(tries);
    rd(9'h0a0, 1);
    wp = 1'b0;
    $display("t_protect done");
  endtask : t_protect
  task automatic t_select();
    logic k;
    mst_u.start_c();
    mst_u.put_byte({iee_pkg::DEV_TYPE_ID, ~ce, 2'h0}, k);
    chk(9'(k), 9'h000);
    mst_u.start_c();
    mst_u.put_byte({~iee_pkg::DEV_TYPE_ID, ce, 2'h0}, k);
    chk(9'(k), 9'h000);
    mst_u.stop_c();
    $display("t_select done");
  endtask : t_select
  // Stop in mid-byte must drop the accepted byte
  task automatic t_stop_slot();
    logic k;
    head(9'h020, k);
    mst_u.put_byte(8'h99, k);
    chk(9'(k), 9'h001);
    for (int i = 0; i < 3; i++) mst_u.bit_c(1'b0, k);
    mst_u.stop_c();
    chk(9'(write_busy), 9'h000);
    rd(9'h020, 1);
    $display("t_stop_slot done");
  endtask : t_stop_slot
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Hang guard, far above the expected run length
  always @(negedge sys_clk) begin
    cyc++;
    if (cyc == 50000) begin
      failures++;
      print_verdict();
    end
  end
  // Reset, wait out the erase sweep, then the scenarios
  initial begin
    foreach (img[i]) img[i] = 8'hff;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 700 && write_busy !== 1'b0; i++) @(negedge sys_clk);
    chk(9'(write_busy), 9'h000);
    mst_u.hc(4);
    t_page();
    t_protect();
    t_select();
    t_stop_slot();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
